// File: rtl/cbte_cfg.svh
`ifndef CBTE_CFG_SVH
`define CBTE_CFG_SVH
// ----------------------------------------
// Status flag positions
// ----------------------------------------
`define CBTE_FLAG_C 3'h0
`define CBTE_FLAG_Z 3'h1
`define CBTE_FLAG_N 3'h2
`define CBTE_FLAG_V 3'h3
`define CBTE_FLAG_S 3'h4
`define CBTE_FLAG_H 3'h5
`define CBTE_FLAG_T 3'h6
`define CBTE_FLAG_I 3'h7
// ----------------------------------------
// Register file layout
// ----------------------------------------
`define CBTE_REG_R0 5'h00
`define CBTE_PTR_X_LO 5'h1a
`define CBTE_PTR_Y_LO 5'h1c
`define CBTE_PTR_Z_LO 5'h1e
`define CBTE_PTR_HI_BIT 5'h01
// ----------------------------------------
// Reset values and steps
// ----------------------------------------
`define CBTE_PC_RESET 16'h0000
`define CBTE_SP_RESET 16'h00ff
`define CBTE_FLAGS_RESET 8'h00
`define CBTE_BYTE_ZERO 8'h00
`define CBTE_BYTE_ONE 8'h01
`define CBTE_STEP_ONE 16'h0001
`define CBTE_STEP_TWO 16'h0002
`define CBTE_DISP_PAD 10'h000
`endif

// File: rtl/cbte_pkg.sv
`default_nettype none
package cbte_pkg;
    typedef enum logic [4:0] {
        OP_NONE = 5'h00, OP_BR_VC = 5'h01, OP_BR_IE = 5'h02, OP_BR_ID = 5'h03,
        OP_IO_SET = 5'h04, OP_IO_CLR = 5'h05, OP_ROL = 5'h06, OP_ROR = 5'h07,
        OP_ASR = 5'h08, OP_FLAG_SET = 5'h09, OP_FLAG_CLR = 5'h0a, OP_BST = 5'h0b,
        OP_BLD = 5'h0c, OP_LD = 5'h0d, OP_ST = 5'h0e, OP_LDS = 5'h0f,
        OP_STS = 5'h10, OP_LPM = 5'h11, OP_PUSH = 5'h12
    } cbte_op_t;
    typedef enum logic [2:0] {
        AM_PLAIN = 3'h0, AM_POSTINC = 3'h1, AM_PREDEC = 3'h2, AM_DISP = 3'h3, AM_IMPLIED = 3'h4
    } cbte_amode_t;
    typedef enum logic [1:0] {PTR_X = 2'h0, PTR_Y = 2'h1, PTR_Z = 2'h2} cbte_ptr_t;
    typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_EXEC2 = 2'b01, ST_EXEC3 = 2'b11} cbte_state_t;
endpackage
`default_nettype wire

// File: rtl/cbte_shift_unit.sv
`default_nettype none
`include "cbte_cfg.svh"
module cbte_shift_unit
    import cbte_pkg::*;
(
    input wire cbte_op_t shift_op,
    input wire logic [7:0] operand,
    input wire logic carry_in,
    output logic [7:0] result,
    output logic carry_out,
    output logic neg,
    output logic ovf,
    output logic zero
);
    wire logic [7:0] rol_val = {operand[6:0], carry_in};
    wire logic [7:0] ror_val = {carry_in, operand[7:1]};
    // Sign bit is kept, not fed from carry
    wire logic [7:0] asr_val = {operand[7], operand[7:1]};
    assign result = (shift_op == OP_ROL) ? rol_val : (shift_op == OP_ROR) ? ror_val : asr_val;
    assign carry_out = (shift_op == OP_ROL) ? operand[7] : operand[0];
    assign neg = result[7];
    assign ovf = result[7] ^ carry_out;
    assign zero = (result == `CBTE_BYTE_ZERO);
endmodule // cbte_shift_unit
`default_nettype wire

// File: rtl/cbte_addr_gen.sv
`default_nettype none
`include "cbte_cfg.svh"
module cbte_addr_gen
    import cbte_pkg::*;
(
    input wire logic [15:0] ptr_value,
    input wire cbte_amode_t mode,
    input wire logic [5:0] disp,
    output logic [15:0] eff_addr,
    output logic [15:0] next_ptr,
    output logic writes_ptr
);
    wire logic [15:0] ptr_inc = ptr_value + `CBTE_STEP_ONE;
    wire logic [15:0] ptr_dec = ptr_value - `CBTE_STEP_ONE;
    wire logic [15:0] ptr_disp = ptr_value + {`CBTE_DISP_PAD, disp};
    // Pre-decrement uses the new value as address; post-increment the old
    assign eff_addr = (mode == AM_PREDEC) ? ptr_dec : (mode == AM_DISP) ? ptr_disp : ptr_value;
    assign next_ptr = (mode == AM_PREDEC) ? ptr_dec : ptr_inc;
    assign writes_ptr = (mode == AM_PREDEC) || (mode == AM_POSTINC);
endmodule // cbte_addr_gen
`default_nettype wire

// File: rtl/cbte_exec.sv
`default_nettype none
`include "cbte_cfg.svh"
// Contract
// [RULE1] Overflow-clear branch jumps by offset plus one only when overflow is zero.
// [RULE2] Interrupt-on/off branches jump by offset plus one when I is one/zero.
// [RULE3] Untaken branch takes one cycle, taken branch takes two.
// [RULE4] I/O bit set/clear forces one bit, no flags touched, two cycles.
// [RULE5] Rotate left through carry, updates Z C N V, one cycle.
// [RULE6] Rotate right through carry, updates Z C N V, one cycle.
// [RULE7] Arithmetic shift right keeps bit seven, updates Z C N V, one cycle.
// [RULE8] Single-flag set or clear changes only that flag, one cycle.
// [RULE9] Register bit copied into transfer flag in one cycle.
// [RULE10] Transfer flag written into register bit, flags unchanged, one cycle.
// [RULE11] Post-increment load reads at pointer then increments it, two cycles.
// [RULE12] Pre-decrement load decrements pointer then reads there, two cycles.
// [RULE13] Displaced load reads pointer plus displacement, pointer kept, two cycles.
// [RULE14] Post-increment store writes at pointer then increments it, two cycles.
// [RULE15] Pre-decrement store decrements pointer then writes there, two cycles.
// [RULE16] Displaced store writes pointer plus displacement, pointer kept, two cycles.
// [RULE17] Direct read loads register from absolute address, two cycles.
// [RULE18] Direct write stores register to absolute address, two cycles.
// [RULE19] Code read loads byte at Z into register or r0, optional increment, three cycles.
// [RULE20] Push places register on stack, flags unchanged, two cycles.
// [RULE21] Overflow set/clear forces only the overflow flag, one cycle.
module cbte_exec
    import cbte_pkg::*;
#(
    parameter int NUM_REGS = 32
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic op_valid,
    input wire cbte_op_t op_code,
    input wire cbte_amode_t op_mode,
    input wire cbte_ptr_t op_ptr,
    input wire logic [4:0] op_rd,
    input wire logic [2:0] op_bit,
    input wire logic [2:0] op_flag,
    input wire logic [5:0] op_disp,
    input wire logic [15:0] op_addr,
    input wire logic [6:0] op_offset,
    input wire logic [5:0] op_io,
    input wire logic [7:0] dmem_rdata,
    input wire logic [7:0] pmem_rdata,
    input wire logic [4:0] reg_obs_sel,
    output logic op_ready,
    output logic op_done,
    output logic [15:0] pc,
    output logic [15:0] sp,
    output logic [7:0] status_flags,
    output logic [15:0] dmem_addr,
    output logic [7:0] dmem_wdata,
    output logic dmem_re,
    output logic dmem_we,
    output logic [15:0] pmem_addr,
    output logic pmem_re,
    output logic [5:0] io_addr,
    output logic [7:0] io_bit_mask,
    output logic io_bit_value,
    output logic io_bit_we,
    output logic [7:0] reg_obs_data
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [7:0] flag_mask(input logic [2:0] idx);
        flag_mask = `CBTE_BYTE_ONE << idx;
    endfunction

    function automatic logic [7:0] put_bit(input logic [7:0] val, input logic [2:0] idx, input logic b);
        put_bit = b ? (val | flag_mask(idx)) : (val & ~flag_mask(idx));
    endfunction

    function automatic logic [4:0] ptr_base(input cbte_ptr_t sel);
        ptr_base = (sel == PTR_X) ? `CBTE_PTR_X_LO : (sel == PTR_Y) ? `CBTE_PTR_Y_LO : `CBTE_PTR_Z_LO;
    endfunction

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [7:0] gpr [NUM_REGS];
    cbte_state_t state;
    cbte_state_t next_state;
    logic load_q;
    logic lpm_q;
    logic branch_q;
    logic [4:0] dest_q;
    logic [15:0] target_q;

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    wire logic take = op_ready && op_valid;
    wire logic [7:0] rd_val = gpr[op_rd];
    wire logic is_branch = (op_code == OP_BR_VC) || (op_code == OP_BR_IE) || (op_code == OP_BR_ID);
    wire logic is_shift = (op_code == OP_ROL) || (op_code == OP_ROR) || (op_code == OP_ASR);
    wire logic is_io = (op_code == OP_IO_SET) || (op_code == OP_IO_CLR);
    wire logic is_load = (op_code == OP_LD) || (op_code == OP_LDS);
    wire logic is_store = (op_code == OP_ST) || (op_code == OP_STS) || (op_code == OP_PUSH);
    wire logic is_lpm = (op_code == OP_LPM);
    wire logic is_ptr = (op_code == OP_LD) || (op_code == OP_ST) || is_lpm;
    // Code reads always walk the Z pair
    wire cbte_ptr_t ptr_sel = is_lpm ? PTR_Z : op_ptr;
    wire logic [4:0] ptr_lo = ptr_base(ptr_sel);
    wire logic [4:0] ptr_hi = ptr_lo | `CBTE_PTR_HI_BIT;
    wire logic [15:0] ptr_val = {gpr[ptr_hi], gpr[ptr_lo]};
    wire logic [15:0] eff_addr;
    wire logic [15:0] next_ptr;
    wire logic writes_ptr;
    wire logic br_cond = (op_code == OP_BR_VC) ? !status_flags[`CBTE_FLAG_V] : // RULE1
                         (op_code == OP_BR_IE) ? status_flags[`CBTE_FLAG_I] : // RULE2
                         !status_flags[`CBTE_FLAG_I];
    wire logic br_taken = is_branch && br_cond;
    wire logic multi = br_taken || is_io || is_load || is_store || is_lpm; // RULE3
    wire logic [15:0] br_target = pc + {{9{op_offset[6]}}, op_offset} + `CBTE_STEP_ONE;
    // Absolute address forms occupy a second program word
    wire logic two_words = (op_code == OP_LDS) || (op_code == OP_STS);
    wire logic [15:0] pc_step = pc + (two_words ? `CBTE_STEP_TWO : `CBTE_STEP_ONE);
    wire logic [15:0] mem_addr = two_words ? op_addr : (op_code == OP_PUSH) ? sp : eff_addr;
    wire logic [4:0] load_dest = (op_mode == AM_IMPLIED) ? `CBTE_REG_R0 : op_rd; // RULE19
    wire logic ptr_update = take && is_ptr && writes_ptr && (op_mode != AM_DISP); // RULE11 RULE12 RULE14 RULE15
    wire logic done_now = (state == ST_EXEC3) || ((state == ST_EXEC2) && !lpm_q) || (take && !multi);

    // ----------------------------------------
    // Shifts and flags
    // ----------------------------------------
    wire logic [7:0] sh_res;
    wire logic sh_c;
    wire logic sh_n;
    wire logic sh_v;
    wire logic sh_z;

    cbte_shift_unit u_shift (
        .shift_op(op_code),
        .operand(rd_val),
        .carry_in(status_flags[`CBTE_FLAG_C]),
        .result(sh_res),
        .carry_out(sh_c),
        .neg(sh_n),
        .ovf(sh_v),
        .zero(sh_z)
    );

    cbte_addr_gen u_addr (
        .ptr_value(ptr_val),
        .mode(op_mode),
        .disp(op_disp),
        .eff_addr(eff_addr),
        .next_ptr(next_ptr),
        .writes_ptr(writes_ptr)
    );

    // Only Z C N V move on a shift; S and H stay as they were
    wire logic [7:0] sh_flags = put_bit(put_bit(put_bit(put_bit(status_flags, // RULE5 RULE6 RULE7
        `CBTE_FLAG_C, sh_c), `CBTE_FLAG_Z, sh_z), `CBTE_FLAG_N, sh_n), `CBTE_FLAG_V, sh_v);
    wire logic [7:0] next_flags =
        !take ? status_flags :
        is_shift ? sh_flags :
        (op_code == OP_FLAG_SET) ? (status_flags | flag_mask(op_flag)) : // RULE8 RULE21
        (op_code == OP_FLAG_CLR) ? (status_flags & ~flag_mask(op_flag)) : // RULE8 RULE21
        (op_code == OP_BST) ? put_bit(status_flags, `CBTE_FLAG_T, rd_val[op_bit]) : // RULE9
        status_flags;

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: next_state = (take && multi) ? ST_EXEC2 : ST_IDLE;
            ST_EXEC2: next_state = lpm_q ? ST_EXEC3 : ST_IDLE; // RULE19
            ST_EXEC3: next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= ST_IDLE;
            op_ready <= 1'b1;
            op_done <= 1'b0;
            status_flags <= `CBTE_FLAGS_RESET;
        end else begin
            state <= next_state;
            op_ready <= (next_state == ST_IDLE);
            op_done <= done_now;
            status_flags <= next_flags;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            load_q <= 1'b0;
            lpm_q <= 1'b0;
            branch_q <= 1'b0;
            dest_q <= `CBTE_REG_R0;
            target_q <= `CBTE_PC_RESET;
        end else if (take) begin
            load_q <= is_load;
            lpm_q <= is_lpm;
            branch_q <= br_taken;
            dest_q <= load_dest;
            target_q <= br_target;
        end
    end

    // ----------------------------------------
    // Program counter and stack
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pc <= `CBTE_PC_RESET;
            sp <= `CBTE_SP_RESET;
        end else begin
            if (take && !br_taken) begin
                pc <= pc_step; // RULE1 RULE2 RULE3
            end else if ((state == ST_EXEC2) && branch_q) begin
                pc <= target_q; // RULE1 RULE2 RULE3
            end
            if (take && (op_code == OP_PUSH)) begin
                sp <= sp - `CBTE_STEP_ONE; // RULE20
            end
        end
    end

    // ----------------------------------------
    // Memory and I/O strobes
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            dmem_re <= 1'b0;
            dmem_we <= 1'b0;
            dmem_addr <= `CBTE_PC_RESET;
            dmem_wdata <= `CBTE_BYTE_ZERO;
            pmem_re <= 1'b0;
            pmem_addr <= `CBTE_PC_RESET;
            io_bit_we <= 1'b0;
            io_addr <= 6'h00;
            io_bit_mask <= `CBTE_BYTE_ZERO;
            io_bit_value <= 1'b0;
        end else begin
            dmem_re <= take && is_load; // RULE11 RULE12 RULE13 RULE17
            dmem_we <= take && is_store; // RULE14 RULE15 RULE16 RULE18 RULE20
            pmem_re <= (take && is_lpm) || ((state == ST_EXEC2) && lpm_q); // RULE19
            io_bit_we <= take && is_io; // RULE4
            if (take) begin
                dmem_addr <= mem_addr; // RULE13 RULE16 RULE17 RULE18
                dmem_wdata <= rd_val;
                pmem_addr <= ptr_val;
                io_addr <= op_io;
                io_bit_mask <= flag_mask(op_bit); // RULE4
                io_bit_value <= (op_code == OP_IO_SET);
            end
        end
    end

    // ----------------------------------------
    // Register file
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                gpr[i] <= `CBTE_BYTE_ZERO;
            end
            reg_obs_data <= `CBTE_BYTE_ZERO;
        end else begin
            reg_obs_data <= gpr[reg_obs_sel];
            if (take && is_shift) begin
                gpr[op_rd] <= sh_res; // RULE5 RULE6 RULE7
            end
            if (take && (op_code == OP_BLD)) begin
                gpr[op_rd] <= put_bit(rd_val, op_bit, status_flags[`CBTE_FLAG_T]); // RULE10
            end
            if (ptr_update) begin
                gpr[ptr_lo] <= next_ptr[7:0];
                gpr[ptr_hi] <= next_ptr[15:8];
            end
            if ((state == ST_EXEC2) && load_q) begin
                gpr[dest_q] <= dmem_rdata; // RULE11 RULE12 RULE13 RULE17
            end
            if (state == ST_EXEC3) begin
                gpr[dest_q] <= pmem_rdata; // RULE19
            end
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    sequence s_two_cycle;
        !op_ready ##1 op_ready;
    endsequence

    sequence s_one_cycle;
        op_ready && op_done;
    endsequence

    property p_branch_on_overflow_clear_untaken;
        take && (op_code == OP_BR_VC) && status_flags[`CBTE_FLAG_V] |=> s_one_cycle and (pc == $past(pc) + 16'h0001);
    endproperty
    a_branch_on_overflow_clear_untaken: assert property (p_branch_on_overflow_clear_untaken) else $error("overflow branch taken with V set"); // RULE1 RULE3

    property p_branch_taken;
        take && br_taken |=> s_two_cycle ##0 (pc == $past(target_q) && status_flags == $past(status_flags, 2));
    endproperty
    a_branch_taken: assert property (p_branch_taken) else $error("taken branch target or timing wrong"); // RULE2 RULE3

    property p_io_bit;
        take && is_io |=> io_bit_we && (io_bit_value == $past(op_code == OP_IO_SET)) && !op_ready
            ##1 !io_bit_we && op_ready && $stable(status_flags);
    endproperty
    a_io_bit: assert property (p_io_bit) else $error("io bit write wrong"); // RULE4

    property p_rotate;
        take && (op_code == OP_ROL || op_code == OP_ROR) |=> status_flags[`CBTE_FLAG_C] ==
            (($past(op_code) == OP_ROL) ? $past(rd_val[7]) : $past(rd_val[0])) && op_ready;
    endproperty
    a_rotate: assert property (p_rotate) else $error("rotate carry wrong"); // RULE5 RULE6

    property p_asr;
        take && (op_code == OP_ASR) |=> status_flags[`CBTE_FLAG_N] == $past(rd_val[7]) &&
            status_flags[`CBTE_FLAG_C] == $past(rd_val[0]);
    endproperty
    a_asr: assert property (p_asr) else $error("shift right flags wrong"); // RULE7

    property p_flag_op;
        take && (op_code == OP_FLAG_SET || op_code == OP_FLAG_CLR) |=> status_flags ==
            (($past(op_code) == OP_FLAG_SET) ? ($past(status_flags) | $past(flag_mask(op_flag)))
                                             : ($past(status_flags) & ~$past(flag_mask(op_flag))));
    endproperty
    a_flag_op: assert property (p_flag_op) else $error("single flag op touched other flags"); // RULE8 RULE21

    property p_bst;
        take && (op_code == OP_BST) |=> status_flags[`CBTE_FLAG_T] == $past(rd_val[op_bit]);
    endproperty
    a_bst: assert property (p_bst) else $error("transfer flag not copied"); // RULE9

    property p_load;
        take && is_load |=> dmem_re && dmem_addr == $past(mem_addr) ##0 s_two_cycle ##0 !dmem_re;
    endproperty
    a_load: assert property (p_load) else $error("load timing or address wrong"); // RULE11 RULE12 RULE13 RULE17

    property p_store;
        take && is_store |=> dmem_we && dmem_wdata == $past(rd_val) && $stable(status_flags) ##1 !dmem_we;
    endproperty
    a_store: assert property (p_store) else $error("store data wrong"); // RULE14 RULE15 RULE16 RULE18 RULE20

    property p_predec;
        take && is_ptr && (op_mode == AM_PREDEC) |=> dmem_addr == $past(ptr_val) - 16'h0001;
    endproperty
    a_predec: assert property (p_predec) else $error("pre-decrement address wrong"); // RULE12 RULE15

    property p_lpm;
        take && is_lpm |=> pmem_re [*2] ##1 (op_ready && op_done && !pmem_re);
    endproperty
    a_lpm: assert property (p_lpm) else $error("code read not three cycles"); // RULE19
endmodule // cbte_exec
`default_nettype wire

// File: tb/cbte_exec_tb.sv
`default_nettype none
module cpu_bit_and_transfer_exec_tb_top
    import cbte_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, arst_n, op_valid, op_ready, op_done, dmem_re, dmem_we, pmem_re, io_bit_value, io_bit_we;
    cbte_op_t op_code;
    cbte_amode_t op_mode;
    cbte_ptr_t op_ptr;
    logic [4:0] op_rd, reg_obs_sel;
    logic [2:0] op_bit, op_flag;
    logic [5:0] op_disp, op_io, io_addr;
    logic [15:0] op_addr, pc, sp, dmem_addr, pmem_addr, c_addr, p;
    logic [6:0] op_offset;
    logic [7:0] dmem_rdata, pmem_rdata, status_flags, dmem_wdata, io_bit_mask, reg_obs_data, c_wdata, ef;
    logic c_re, c_we, c_iowe, c_pre;
    int num_errors = 0;
    int samples_checked = 0;

    cbte_exec u_cbte_exec (.core_clk(core_clk), .arst_n(arst_n), .op_valid(op_valid), .op_code(op_code),
        .op_mode(op_mode), .op_ptr(op_ptr), .op_rd(op_rd), .op_bit(op_bit), .op_flag(op_flag),
        .op_disp(op_disp), .op_addr(op_addr), .op_offset(op_offset), .op_io(op_io),
        .dmem_rdata(dmem_rdata), .pmem_rdata(pmem_rdata), .reg_obs_sel(reg_obs_sel), .op_ready(op_ready),
        .op_done(op_done), .pc(pc), .sp(sp), .status_flags(status_flags), .dmem_addr(dmem_addr),
        .dmem_wdata(dmem_wdata), .dmem_re(dmem_re), .dmem_we(dmem_we), .pmem_addr(pmem_addr),
        .pmem_re(pmem_re), .io_addr(io_addr), .io_bit_mask(io_bit_mask), .io_bit_value(io_bit_value),
        .io_bit_we(io_bit_we), .reg_obs_data(reg_obs_data));

    // ----------------------------------------
    // Checking and driving helpers
    // ----------------------------------------
    task automatic test_done();
        if (num_errors == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        chk16({8'h00, got}, {8'h00, exp});
    endtask

    task automatic op(input cbte_op_t c, input cbte_amode_t m, input cbte_ptr_t pt, input logic [4:0] r);
        op_code = c;
        op_mode = m;
        op_ptr = pt;
        op_rd = r;
    endtask

    // Issue one request, capture strobes of cycle 1, check cycles to done
    task automatic go(input int ncyc);
        int n;
        n = 0;
        op_valid = 1'b1;
        @(posedge core_clk);
        #1;
        op_valid = 1'b0;
        // Data and I/O strobes launched by the take edge stand only until the next edge; pmem_re stays up for two cycles
        n = 1;
        c_re = dmem_re;
        c_we = dmem_we;
        c_iowe = io_bit_we;
        c_pre = pmem_re;
        c_addr = dmem_addr;
        c_wdata = dmem_wdata;
        while (op_done !== 1'b1 && n < 8) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        chk16(16'(n), 16'(ncyc));
        chk8({7'h00, op_ready}, 8'h01);
    endtask

    task automatic rdr(input logic [4:0] s, input logic [7:0] e);
        reg_obs_sel = s;
        repeat (2) @(posedge core_clk);
        #1;
        chk8(reg_obs_data, e);
    endtask

    task automatic ldreg(input logic [4:0] r, input logic [7:0] v);
        op(OP_LDS, AM_PLAIN, PTR_X, r);
        op_addr = 16'h0100 + 16'(r);
        dmem_rdata = v;
        go(2);
        chk16(c_addr, 16'h0100 + 16'(r));
        chk8({7'h00, c_re}, 8'h01);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_flags();
        for (int f = 0; f < 16; f++) begin
            op(f < 8 ? OP_FLAG_SET : OP_FLAG_CLR, AM_IMPLIED, PTR_X, 5'h00);
            op_flag = 3'(f);
            ef = f < 8 ? (ef | (8'h01 << f[2:0])) : (ef & ~(8'h01 << f[2:0]));
            go(1);
            chk8(status_flags, ef);
        end
    endtask

    task automatic t_shift();
        ldreg(5'h05, 8'h81);
        op(OP_ROL, AM_IMPLIED, PTR_X, 5'h05);
        go(1);
        chk8(status_flags, 8'h09);
        rdr(5'h05, 8'h02);
        op_code = OP_ROR;
        go(1);
        chk8(status_flags, 8'h0c);
        rdr(5'h05, 8'h81);
        op_code = OP_ASR;
        go(1);
        chk8(status_flags, 8'h05);
        rdr(5'h05, 8'hc0);
        ef = 8'h05;
    endtask

    // Entries: code, offset, flag preset (bit 3 set V, bit 7 set I), taken
    task automatic t_branch();
        cbte_op_t codes[6] = '{OP_BR_VC, OP_BR_VC, OP_BR_ID, OP_BR_IE, OP_BR_IE, OP_BR_ID};
        logic [6:0] offs[6] = '{7'h05, 7'h05, 7'h7e, 7'h04, 7'h03, 7'h09};
        bit taken[6] = '{1, 0, 1, 0, 1, 0};
        for (int i = 0; i < 6; i++) begin
            if (i == 1 || i == 4) begin
                op(OP_FLAG_SET, AM_IMPLIED, PTR_X, 5'h00);
                op_flag = (i == 1) ? 3'h3 : 3'h7;
                ef = ef | (8'h01 << op_flag);
                go(1);
            end
            op(codes[i], AM_IMPLIED, PTR_X, 5'h00);
            op_offset = offs[i];
            p = pc;
            go(taken[i] ? 2 : 1);
            chk16(pc, taken[i] ? p + {{9{offs[i][6]}}, offs[i]} + 16'h0001 : p + 16'h0001);
            chk8(status_flags, ef);
        end
    endtask

    task automatic mem(input cbte_op_t c, input cbte_amode_t m, input cbte_ptr_t pt, input logic [15:0] a,
                       input logic [4:0] pr, input logic [7:0] pv);
        op(c, m, pt, 5'h07);
        go(2);
        chk16(c_addr, a);
        chk8({6'h00, c_re, c_we}, c == OP_ST ? 8'h01 : 8'h02);
        if (c == OP_ST) chk8(c_wdata, 8'h3c);
        rdr(pr, pv);
    endtask

    task automatic t_ptr();
        ldreg(5'h1a, 8'h10);
        ldreg(5'h1b, 8'h02);
        ldreg(5'h1c, 8'h40);
        ldreg(5'h1d, 8'h00);
        ldreg(5'h1e, 8'hfe);
        ldreg(5'h1f, 8'h00);
        dmem_rdata = 8'h3c;
        mem(OP_LD, AM_POSTINC, PTR_X, 16'h0210, 5'h1a, 8'h11);
        rdr(5'h07, 8'h3c);
        mem(OP_LD, AM_PREDEC, PTR_X, 16'h0210, 5'h1a, 8'h10);
        op_disp = 6'h3f;
        mem(OP_LD, AM_DISP, PTR_Y, 16'h007f, 5'h1c, 8'h40);
        mem(OP_ST, AM_POSTINC, PTR_Z, 16'h00fe, 5'h1e, 8'hff);
        mem(OP_ST, AM_PREDEC, PTR_Z, 16'h00fe, 5'h1e, 8'hfe);
        op_disp = 6'h01;
        mem(OP_ST, AM_DISP, PTR_Y, 16'h0041, 5'h1c, 8'h40);
        op(OP_STS, AM_PLAIN, PTR_X, 5'h07);
        op_addr = 16'h1234;
        go(2);
        chk16(c_addr, 16'h1234);
        chk8({c_we, c_wdata[6:0]}, 8'hbc);
    endtask

    task automatic t_misc();
        pmem_rdata = 8'ha5;
        op(OP_LPM, AM_IMPLIED, PTR_Z, 5'h09);
        go(3);
        chk16({c_pre, pmem_addr[14:0]}, 16'h80fe);
        rdr(5'h00, 8'ha5);
        op(OP_LPM, AM_POSTINC, PTR_Z, 5'h08);
        go(3);
        rdr(5'h08, 8'ha5);
        rdr(5'h1e, 8'hff);
        for (int i = 0; i < 2; i++) begin
            op(i == 0 ? OP_IO_SET : OP_IO_CLR, AM_IMPLIED, PTR_X, 5'h00);
            op_io = 6'h2a;
            op_bit = i == 0 ? 3'h3 : 3'h7;
            go(2);
            chk16({c_iowe, io_bit_value, io_addr, io_bit_mask}, i == 0 ? 16'hea08 : 16'haa80);
            chk8(status_flags, ef);
        end
        op(OP_BST, AM_IMPLIED, PTR_X, 5'h05);
        op_bit = 3'h6;
        ef = ef | 8'h40;
        go(1);
        chk8(status_flags, ef);
        op(OP_BLD, AM_IMPLIED, PTR_X, 5'h07);
        op_bit = 3'h0;
        go(1);
        chk8(status_flags, ef);
        rdr(5'h07, 8'h3d);
        op(OP_PUSH, AM_IMPLIED, PTR_X, 5'h07);
        go(2);
        chk16(c_addr, 16'h00ff);
        chk16({c_wdata, status_flags}, {8'h3d, ef});
        chk16(sp, 16'h00fe);
    endtask

    // ----------------------------------------
    // Clock, reset, sequence and watchdog
    // ----------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    initial begin
        arst_n = 1'b0;
        op_valid = 1'b0;
        op(OP_NONE, AM_PLAIN, PTR_X, 5'h00);
        {op_bit, op_flag, op_disp, op_io, op_offset} = '0;
        {op_addr, dmem_rdata, pmem_rdata, reg_obs_sel} = '0;
        ef = 8'h00;
        repeat (12) @(posedge core_clk);
        #1;
        arst_n = 1'b1;
        chk16(sp, 16'h00ff);
        t_flags();
        t_shift();
        t_branch();
        t_ptr();
        t_misc();
        test_done();
    end

    // Whole sequence needs well under 1000 cycles
    initial begin
        repeat (5000) @(posedge core_clk);
        num_errors++;
        test_done();
    end
endmodule // cpu_bit_and_transfer_exec_tb_top
`default_nettype wire
